// [rtl/ramp_supervisor_regs.vh]
`ifndef RAMP_SUPERVISOR_REGS_VH
`define RAMP_SUPERVISOR_REGS_VH

// Register addresses
`define ADDR_THRESH      8'h01
`define ADDR_RAMP        8'h03
`define ADDR_ON_DLY      8'h05
`define ADDR_OFF_DLY     8'h06
`define ADDR_RUN         8'h15
`define ADDR_STATUS      8'h16
`define ADDR_PG_DLY      8'h1a

// Ramp rate configuration fields
`define F_RISE_RATE      6:4
`define F_FALL_EN        3
`define F_FALL_RATE      2:0
`define RAMP_RESET       8'h5c
`define FALL_TERM_CODE   3'h3

// Threshold configuration fields
`define F_PG_HI          5
`define F_PG_LO          4
`define F_OV             3:2
`define F_UV             1:0
`define THRESH_RESET     8'h08
`define THRESH_MASK      8'h3f

// Run and status fields
`define F_RUN            0
`define F_PG_IMMED       1
`define RUN_RESET        8'h00
`define DLY_RESET        8'h00
`define F_ST_PG          0
`define F_ST_TW          1

// Percent levels of the set-point
`define PCT_75           8'h4b
`define PCT_80           8'h50
`define PCT_85           8'h55
`define PCT_90           8'h5a
`define PCT_95           8'h5f
`define PCT_105          8'h69
`define PCT_110          8'h6e
`define PCT_120          8'h78
`define PCT_130          8'h82
`define PCT_FULL         20'h00064

// Ramp step of 10 mV at 2.5 mV per LSB
`define STEP_LSB         12'h004

// Temperature warning hysteresis, degrees C; power-good delay cap, ms
`define TEMP_WARN_SET    8'h78
`define TEMP_WARN_CLR    8'h75
`define PG_DLY_MAX       8'h96

// Step durations in ns for rate codes 0..7
`define STEP_NS_0        200000
`define STEP_NS_1        100000
`define STEP_NS_2        50000
`define STEP_NS_3        40000
`define STEP_NS_4        20000
`define STEP_NS_5        10000
`define STEP_NS_6        5000
`define STEP_NS_7        2000
`define MASTER_NS        1000
`define MS_NS            1000000

`endif

// [rtl/tick_divider.v]
// Counts enable pulses and emits one pulse per period of them
module tick_divider #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         restart,
  input  wire         enable,
  input  wire [W-1:0] period,
  output reg          pulse
);

  reg [W-1:0] cnt_reg;

  // Restart realigns the phase so a new ramp gets a full first step
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= {W{1'b0}};
      pulse   <= 1'b0;
    end
    else if (restart)
    begin
      cnt_reg <= {W{1'b0}};
      pulse   <= 1'b0;
    end
    else if (enable)
    begin
      if (cnt_reg >= period - {{(W-1){1'b0}}, 1'b1})
      begin
        cnt_reg <= {W{1'b0}};
        pulse   <= 1'b1;
      end
      else
      begin
        cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
        pulse   <= 1'b0;
      end
    end
    else
    begin
      pulse <= 1'b0;
    end
  end

endmodule

// [rtl/output_ramp_power_good_supervisor.v]
`include "ramp_supervisor_regs.vh"

// Contract
// - Target moves toward set-point in 10 mV steps; step time sets slew.
// - Step duration comes from dividing the manager's master clock.
// - Rising codes 5, 6, 7 give 1, 2, 5 V/ms.
// - Ramp config bit 3 enables controlled fall; resets enabled.
// - Bits 2:0 pick fall rate; default 4, or 3 as bus terminator.
// - Switching stays off until ramp target passes the pre-bias level.
// - Threshold config writable only when run is 0; top bits read 0.
// - Bit 4 picks power-good low limit: 1 is 95%, 0 is 90%.
// - Bits 3:2 pick over-voltage 110, 120, 130, 130 percent; reset 10.
// - Bits 1:0 pick under-voltage 75, 80, 85, 90 percent; reset 00.
// - Bit 5 picks power-good high limit 105 or 110 percent.
// - All levels follow the active set-point whenever it changes.
// - Thermal warning sets above 120 C, clears below 117 C.
// - Warnings only update status and pins, never stop the output.
// - Power-good pin driven low when output is outside the window.
// - Window checking starts only once the ramp reaches steady state.
// - Power-good release waits a programmable 0 to 150 ms delay.
// - Monitoring stays active while the set-point moves between margins.
// - Warning drives pin low, status bit 0; recovery releases both.
// - External low on the power-good pin counts as a warning.
// - Option: power-good drops at turn-off command or at ramp-down start.
// - Turn-on delay counts from turn-on command to ramp start.
module output_ramp_power_good_supervisor #(
  parameter MASTER_PERIOD_NS = `MASTER_NS,
  parameter MS_TICKS         = `MS_NS / `MASTER_NS
) (
  input  wire        REF_CLK,
  input  wire        RST,
  input  wire        MASTER_CLK,
  input  wire        BUS_TERM,
  input  wire        WR_STROBE,
  input  wire [7:0]  WR_ADDR,
  input  wire [7:0]  WR_DATA,
  input  wire [7:0]  RD_ADDR,
  input  wire [11:0] SETPOINT,
  input  wire [11:0] VOUT_MEAS,
  input  wire [7:0]  TEMP,
  input  wire        PG_IN,
  output reg  [7:0]  RD_DATA,
  output reg  [11:0] TARGET,
  output reg         PWM_EN,
  output reg         RAMP_STEADY,
  output reg  [12:0] OV_LEVEL,
  output reg  [12:0] UV_LEVEL,
  output reg         PG_OUT,
  output reg         PG_OE,
  output reg         THERMAL_WARN
);

  localparam S_OFF     = 3'h0;
  localparam S_ON_DLY  = 3'h1;
  localparam S_RISE    = 3'h2;
  localparam S_STEADY  = 3'h3;
  localparam S_OFF_DLY = 3'h4;
  localparam S_FALL    = 3'h5;

  reg  [7:0]  ramp_rate_config;
  reg  [7:0]  threshold_config;
  reg  [7:0]  run_reg;
  reg  [7:0]  on_dly_reg;
  reg  [7:0]  off_dly_reg;
  reg  [7:0]  pg_dly_reg;
  reg         strap_done_reg;
  reg         master_q_reg;
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [2:0]  state_d_reg;
  reg  [11:0] prebias_reg;
  reg  [7:0]  dly_cnt_reg;
  reg         armed_reg;
  reg  [7:0]  pg_cnt_reg;
  reg         power_good;
  reg  [12:0] pg_hi_reg;
  reg  [12:0] pg_lo_reg;
  reg  [7:0]  ov_pct;
  reg  [7:0]  uv_pct;
  reg  [7:0]  hi_pct;
  reg  [7:0]  lo_pct;
  reg  [11:0] up_target;
  reg  [11:0] down_target;
  wire        master_tick;
  wire        step_tick;
  wire        ms_tick;
  wire        run_on;
  wire        restart;
  wire [2:0]  rate_code;
  wire [7:0]  pg_dly_lim;
  wire        pg_released;
  wire        window_ok;

  // Step time in master ticks, never below one tick
  function [15:0] step_ticks;
    input [2:0] code;
    integer ns;
    integer t;
    begin
      case (code)
        3'h0:    ns = `STEP_NS_0;
        3'h1:    ns = `STEP_NS_1;
        3'h2:    ns = `STEP_NS_2;
        3'h3:    ns = `STEP_NS_3;
        3'h4:    ns = `STEP_NS_4;
        3'h5:    ns = `STEP_NS_5;
        3'h6:    ns = `STEP_NS_6;
        default: ns = `STEP_NS_7;
      endcase
      t = ns / MASTER_PERIOD_NS;
      if (t < 1)
        t = 1;
      step_ticks = t[15:0];
    end
  endfunction

  // Percentage of the set-point, wide enough for 130% of full scale
  function [12:0] pct_of;
    input [11:0] sp;
    input [7:0]  pct;
    reg   [19:0] p;
    begin
      p = {8'h00, sp} * {12'h000, pct};
      p = p / `PCT_FULL;
      pct_of = p[12:0];
    end
  endfunction

  // Master clock is synchronous here, so a plain edge detect suffices
  assign master_tick = MASTER_CLK & ~master_q_reg;
  assign run_on      = run_reg[`F_RUN];
  assign restart     = (state_reg != state_d_reg);
  assign rate_code   = (state_reg == S_FALL) ? ramp_rate_config[`F_FALL_RATE]
                                             : ramp_rate_config[`F_RISE_RATE];

  // Ramp step timing from the shared master clock
  tick_divider #(
    .W(16)
  ) step_div (
    .clk     (REF_CLK),
    .rst     (RST),
    .restart (restart),
    .enable  (master_tick),
    .period  (step_ticks(rate_code)),
    .pulse   (step_tick)
  );

  // Millisecond base for delays
  tick_divider #(
    .W(16)
  ) ms_div (
    .clk     (REF_CLK),
    .rst     (RST),
    .restart (1'b0),
    .enable  (master_tick),
    .period  (MS_TICKS[15:0]),
    .pulse   (ms_tick)
  );

  // Register writes; strap caught on the first edge after release
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      ramp_rate_config <= `RAMP_RESET;
      threshold_config <= `THRESH_RESET;
      run_reg          <= `RUN_RESET;
      on_dly_reg       <= `DLY_RESET;
      off_dly_reg      <= `DLY_RESET;
      pg_dly_reg       <= `DLY_RESET;
      strap_done_reg   <= 1'b0;
      master_q_reg     <= 1'b0;
    end
    else
    begin
      master_q_reg   <= MASTER_CLK;
      strap_done_reg <= 1'b1;
      if (!strap_done_reg && BUS_TERM)
        ramp_rate_config[`F_FALL_RATE] <= `FALL_TERM_CODE;
      if (WR_STROBE)
      begin
        case (WR_ADDR)
          `ADDR_RAMP:    ramp_rate_config <= WR_DATA;
          `ADDR_THRESH:
          begin
            if (!run_on)
              threshold_config <= WR_DATA & `THRESH_MASK;
          end
          `ADDR_RUN:     run_reg <= WR_DATA;
          `ADDR_ON_DLY:  on_dly_reg <= WR_DATA;
          `ADDR_OFF_DLY: off_dly_reg <= WR_DATA;
          `ADDR_PG_DLY:  pg_dly_reg <= WR_DATA;
          default:       ;
        endcase
      end
    end
  end

  // Step-up and step-down candidates clamped at set-point and zero
  always @*
  begin
    if (TARGET + `STEP_LSB >= SETPOINT || TARGET + `STEP_LSB < TARGET)
      up_target = SETPOINT;
    else
      up_target = TARGET + `STEP_LSB;
    if (TARGET <= `STEP_LSB)
      down_target = 12'h000;
    else
      down_target = TARGET - `STEP_LSB;
  end

  // Sequencer next state
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      S_OFF:
        if (run_on)
          state_next = S_ON_DLY;
      S_ON_DLY:
        if (!run_on)
          state_next = S_OFF;
        else if (dly_cnt_reg >= on_dly_reg)
          state_next = S_RISE;
      S_RISE:
        if (!run_on)
          state_next = S_OFF_DLY;
        else if (TARGET == SETPOINT)
          state_next = S_STEADY;
      S_STEADY:
        if (!run_on)
          state_next = S_OFF_DLY;
      S_OFF_DLY:
        if (run_on)
          state_next = S_STEADY;
        else if (dly_cnt_reg >= off_dly_reg)
          state_next = ramp_rate_config[`F_FALL_EN] ? S_FALL : S_OFF;
      S_FALL:
        if (TARGET == 12'h000)
          state_next = S_OFF;
      default:
        state_next = S_OFF;
    endcase
  end

  // Sequencer state, delay counting and target stepping
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg   <= S_OFF;
      state_d_reg <= S_OFF;
      dly_cnt_reg <= 8'h00;
      prebias_reg <= 12'h000;
      TARGET      <= 12'h000;
      PWM_EN      <= 1'b0;
      RAMP_STEADY <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      state_d_reg <= state_reg;
      if (state_next != state_reg)
        dly_cnt_reg <= 8'h00;
      else if (ms_tick && dly_cnt_reg != 8'hff)
        dly_cnt_reg <= dly_cnt_reg + 8'h01;
      if (state_reg == S_OFF && run_on)
        prebias_reg <= VOUT_MEAS;
      RAMP_STEADY <= (state_next == S_STEADY) && (TARGET == SETPOINT);
      case (state_reg)
        S_OFF:
        begin
          TARGET <= 12'h000;
          PWM_EN <= 1'b0;
        end
        S_RISE:
        begin
          if (step_tick)
            TARGET <= up_target;
          PWM_EN <= PWM_EN | (TARGET > prebias_reg);
        end
        S_STEADY:
        begin
          // Margin moves ramp too, at the rising rate; parks on the set-point
          if (step_tick && TARGET < SETPOINT)
            TARGET <= up_target;
          else if (step_tick && TARGET > SETPOINT)
            TARGET <= (down_target < SETPOINT) ? SETPOINT : down_target;
          PWM_EN <= 1'b1;
        end
        S_FALL:
        begin
          if (step_tick)
            TARGET <= down_target;
          if (state_next == S_OFF)
            PWM_EN <= 1'b0;
        end
        S_OFF_DLY:
        begin
          if (state_next == S_OFF)
            PWM_EN <= 1'b0;
        end
        default:
          ;
      endcase
    end
  end

  // Percent selections from the threshold fields
  always @*
  begin
    case (threshold_config[`F_OV])
      2'b00:   ov_pct = `PCT_110;
      2'b01:   ov_pct = `PCT_120;
      default: ov_pct = `PCT_130;
    endcase
    case (threshold_config[`F_UV])
      2'b00:   uv_pct = `PCT_75;
      2'b01:   uv_pct = `PCT_80;
      2'b10:   uv_pct = `PCT_85;
      default: uv_pct = `PCT_90;
    endcase
    hi_pct = threshold_config[`F_PG_HI] ? `PCT_110 : `PCT_105;
    lo_pct = threshold_config[`F_PG_LO] ? `PCT_95 : `PCT_90;
  end

  // Levels recomputed every cycle, so set-point changes land next edge
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      OV_LEVEL  <= 13'h0000;
      UV_LEVEL  <= 13'h0000;
      pg_hi_reg <= 13'h0000;
      pg_lo_reg <= 13'h0000;
    end
    else
    begin
      OV_LEVEL  <= pct_of(SETPOINT, ov_pct);
      UV_LEVEL  <= pct_of(SETPOINT, uv_pct);
      pg_hi_reg <= pct_of(SETPOINT, hi_pct);
      pg_lo_reg <= pct_of(SETPOINT, lo_pct);
    end
  end

  assign pg_dly_lim  = (pg_dly_reg > `PG_DLY_MAX) ? `PG_DLY_MAX : pg_dly_reg;
  assign pg_released = armed_reg && (pg_cnt_reg >= pg_dly_lim);
  assign window_ok   = ({1'b0, VOUT_MEAS} >= pg_lo_reg) &&
                       ({1'b0, VOUT_MEAS} <= pg_hi_reg);

  // Power-good arming, release delay, pin and status bit
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      armed_reg  <= 1'b0;
      pg_cnt_reg <= 8'h00;
      power_good <= 1'b0;
      PG_OE      <= 1'b1;
      PG_OUT     <= 1'b0;
    end
    else
    begin
      PG_OUT <= 1'b0;
      if (state_reg == S_RISE && state_next == S_STEADY)
        armed_reg <= 1'b1;
      else if (run_reg[`F_PG_IMMED] && !run_on)
        armed_reg <= 1'b0;
      else if (state_next == S_FALL || state_next == S_OFF)
        armed_reg <= 1'b0;
      if (!armed_reg)
        pg_cnt_reg <= 8'h00;
      else if (ms_tick && pg_cnt_reg < pg_dly_lim)
        pg_cnt_reg <= pg_cnt_reg + 8'h01;
      // Pin and status bit only; warnings never touch the sequencer
      PG_OE      <= !(pg_released && window_ok);
      power_good <= pg_released && window_ok && PG_IN;
    end
  end

  // Thermal warning with 3 C of hysteresis
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      THERMAL_WARN <= 1'b0;
    else if (TEMP > `TEMP_WARN_SET)
      THERMAL_WARN <= 1'b1;
    else if (TEMP < `TEMP_WARN_CLR)
      THERMAL_WARN <= 1'b0;
  end

  // Registered read port for the manager's polling
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      RD_DATA <= 8'h00;
    else
    begin
      case (RD_ADDR)
        `ADDR_RAMP:    RD_DATA <= ramp_rate_config;
        `ADDR_THRESH:  RD_DATA <= threshold_config & `THRESH_MASK;
        `ADDR_RUN:     RD_DATA <= run_reg;
        `ADDR_ON_DLY:  RD_DATA <= on_dly_reg;
        `ADDR_OFF_DLY: RD_DATA <= off_dly_reg;
        `ADDR_PG_DLY:  RD_DATA <= pg_dly_reg;
        `ADDR_STATUS:
        begin
          RD_DATA              <= 8'h00;
          RD_DATA[`F_ST_PG]    <= power_good;
          RD_DATA[`F_ST_TW]    <= THERMAL_WARN;
        end
        default:       RD_DATA <= 8'h00;
      endcase
    end
  end

endmodule

// [dv/supervisor_asserts.sv]
`include "ramp_supervisor_regs.vh"

module supervisor_asserts (
  input logic        REF_CLK,
  input logic        RST,
  input logic [7:0]  RD_ADDR,
  input logic [11:0] SETPOINT,
  input logic [7:0]  TEMP,
  input logic [7:0]  RD_DATA,
  input logic [11:0] TARGET,
  input logic        PWM_EN,
  input logic        RAMP_STEADY,
  input logic [12:0] OV_LEVEL,
  input logic [12:0] UV_LEVEL,
  input logic        PG_OUT,
  input logic        PG_OE,
  input logic        THERMAL_WARN
);
  timeunit 1ns;
  timeprecision 1ps;
  // Single domain, so clock and reset are given once
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // Thermal hysteresis band
  AST_TEMP_SET: assert property (TEMP > `TEMP_WARN_SET |=> THERMAL_WARN)
    else $error("thermal warning not raised");
  AST_TEMP_CLR: assert property (TEMP < `TEMP_WARN_CLR |=> !THERMAL_WARN)
    else $error("thermal warning not cleared");
  AST_TEMP_HOLD: assert property (TEMP <= `TEMP_WARN_SET && TEMP >= `TEMP_WARN_CLR
    |=> $stable(THERMAL_WARN)) else $error("thermal warning moved inside band");
  // Ramp moves one step at a time, clamps at the ends
  AST_STEP: assert property ($changed(TARGET) |-> TARGET == $past(TARGET) + `STEP_LSB
    || $past(TARGET) == TARGET + `STEP_LSB || TARGET == SETPOINT || TARGET == 12'h000)
    else $error("ramp step not one increment");
  AST_STEADY: assert property (RAMP_STEADY && $stable(SETPOINT) |-> TARGET == SETPOINT)
    else $error("steady flagged off the set-point");
  // Levels stay within the selectable percentage span
  // Levels still hold their reset value on the first edge after release
  AST_OV_RANGE: assert property (!$past(RST) && $stable(SETPOINT)
    |-> OV_LEVEL >= SETPOINT * 110 / 100
    && OV_LEVEL <= SETPOINT * 130 / 100) else $error("over-voltage level out of span");
  AST_UV_RANGE: assert property (!$past(RST) && $stable(SETPOINT)
    |-> UV_LEVEL >= SETPOINT * 75 / 100
    && UV_LEVEL <= SETPOINT * 90 / 100) else $error("under-voltage level out of span");
  AST_THRESH_TOP: assert property (RD_ADDR == `ADDR_THRESH |=> RD_DATA[7:6] == 2'b00)
    else $error("threshold top bits not zero");
  AST_WARN_KEEPS_RUN: assert property (RAMP_STEADY && $rose(THERMAL_WARN) |=> PWM_EN)
    else $error("warning stopped the output");
  AST_PG_HELD_OFF: assert property (!PWM_EN && !$past(PWM_EN) && !RAMP_STEADY |-> PG_OE)
    else $error("power good released while off");
  AST_PG_OPEN_DRAIN: assert property (!PG_OUT)
    else $error("power good driven high");
  AST_PWM_AFTER_RAMP: assert property ($rose(PWM_EN) |-> TARGET != 12'h000)
    else $error("switching before ramp moved");
endmodule

bind output_ramp_power_good_supervisor supervisor_asserts chk_u (.REF_CLK, .RST, .RD_ADDR,
  .SETPOINT, .TEMP, .RD_DATA, .TARGET, .PWM_EN, .RAMP_STEADY, .OV_LEVEL, .UV_LEVEL,
  .PG_OUT, .PG_OE, .THERMAL_WARN);

// [dv/power_manager_model.sv]
module power_manager_model (
  input  logic ref_clk,
  input  logic pg_oe,
  input  logic pg_out,
  input  logic ext_low,
  output logic master_clk,
  output logic pg_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  int div = 0;

  initial master_clk = 1'b0;
  // Shared master clock, 1 MHz, kept in step with the system clock
  always @(negedge ref_clk)
  begin
    div <= (div == 49) ? 0 : div + 1;
    if (div == 49)
      master_clk <= ~master_clk;
  end
  // Weak pull-up loses to any party pulling low
  assign pg_wire = !(pg_oe && !pg_out) && !ext_low;
endmodule

// [dv/tb.sv]
`include "ramp_supervisor_regs.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        REF_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        BUS_TERM = 1'b0;
  logic        WR_STROBE = 1'b0;
  logic [7:0]  WR_ADDR = 8'h00;
  logic [7:0]  WR_DATA = 8'h00;
  logic [7:0]  RD_ADDR = 8'h00;
  logic [11:0] SETPOINT = 12'h0c8;
  logic [11:0] VOUT_MEAS = 12'h000;
  logic [7:0]  TEMP = 8'h19;
  logic        ext_low = 1'b0;
  logic        MASTER_CLK, PG_IN, PWM_EN, RAMP_STEADY, PG_OUT, PG_OE, THERMAL_WARN;
  logic [7:0]  RD_DATA;
  logic [11:0] TARGET;
  logic [12:0] OV_LEVEL, UV_LEVEL;
  int          errors = 0;
  int          compares = 0;
  int          n, gap;
  int          ov_pct[4] = '{110, 120, 130, 130};
  int          uv_pct[4] = '{75, 80, 85, 90};

  // Short millisecond so delays fit the run
  output_ramp_power_good_supervisor #(.MS_TICKS(4)) dut_u (.REF_CLK, .RST, .MASTER_CLK,
    .BUS_TERM, .WR_STROBE, .WR_ADDR, .WR_DATA, .RD_ADDR, .SETPOINT, .VOUT_MEAS, .TEMP,
    .PG_IN, .RD_DATA, .TARGET, .PWM_EN, .RAMP_STEADY, .OV_LEVEL, .UV_LEVEL, .PG_OUT,
    .PG_OE, .THERMAL_WARN);
  power_manager_model pm_u (.ref_clk(REF_CLK), .pg_oe(PG_OE), .pg_out(PG_OUT),
    .ext_low(ext_low), .master_clk(MASTER_CLK), .pg_wire(PG_IN));

  always #5 REF_CLK = ~REF_CLK;

  task automatic close_out();
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp_val(input logic [12:0] got, input logic [12:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_num(input int got, input int exp);
    compares++;
    if (got != exp)
    begin
      errors++;
      $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  // Register port: one-cycle strobe, read data one edge later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge REF_CLK);
    WR_STROBE = 1'b1;
    WR_ADDR = a;
    WR_DATA = d;
    @(negedge REF_CLK);
    WR_STROBE = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge REF_CLK);
    RD_ADDR = a;
    @(negedge REF_CLK);
    cmp_val({5'h00, RD_DATA}, {5'h00, exp});
  endtask
  // Cycles between two successive ramp steps; bounded so a stall shows
  task automatic step_gap(output int g);
    logic [11:0] t;
    int k;
    t = TARGET;
    k = 0;
    while (TARGET === t && k < 1000)
    begin
      @(negedge REF_CLK);
      k++;
    end
    t = TARGET;
    g = 0;
    while (TARGET === t && g < 1000)
    begin
      @(negedge REF_CLK);
      g++;
    end
  endtask

  // Watchdog about twice the length of the three full ramps
  initial
  begin
    #700000;
    errors++;
    close_out();
  end

  initial
  begin
    repeat (4) @(posedge REF_CLK);
    @(negedge REF_CLK);
    RST = 1'b0;
    repeat (2) @(negedge REF_CLK);
    cmp_val(13'(PG_OE), 13'h0001);
    rd(`ADDR_THRESH, 8'h08);
    rd(`ADDR_RAMP, 8'h5c);
    rd(`ADDR_RUN, 8'h00);
    rd(8'h40, 8'h00);
    wr(`ADDR_THRESH, 8'hff);
    rd(`ADDR_THRESH, 8'h3f);
    // Every over- and under-voltage code against the fixed set-point
    for (int i = 0; i < 4; i++)
    begin
      wr(`ADDR_THRESH, {4'h0, i[1:0], i[1:0]});
      repeat (2) @(negedge REF_CLK);
      cmp_val(OV_LEVEL, 13'(200 * ov_pct[i] / 100));
      cmp_val(UV_LEVEL, 13'(200 * uv_pct[i] / 100));
    end
    SETPOINT = 12'h0cd;
    repeat (2) @(negedge REF_CLK);
    cmp_val(OV_LEVEL, 13'(205 * 130 / 100));
    cmp_val(UV_LEVEL, 13'(205 * 90 / 100));
    // Thermal band: set, hold, clear
    TEMP = 8'h79;
    repeat (2) @(negedge REF_CLK);
    rd(`ADDR_STATUS, 8'h02);
    TEMP = 8'h76;
    rd(`ADDR_STATUS, 8'h02);
    TEMP = 8'h74;
    rd(`ADDR_STATUS, 8'h00);
    // Turn-on into a pre-biased output at the fastest rates
    SETPOINT = 12'h0c8;
    VOUT_MEAS = 12'h050;
    wr(`ADDR_THRESH, 8'h08);
    wr(`ADDR_RAMP, 8'h7f);
    wr(`ADDR_PG_DLY, 8'h01);
    wr(`ADDR_RUN, 8'h01);
    for (n = 0; PWM_EN !== 1'b1 && n < 20000; n++) @(negedge REF_CLK);
    cmp_val(13'(PWM_EN), 13'h0001);
    cmp_val(13'(TARGET > 12'h050), 13'h0001);
    step_gap(gap);
    cmp_num(gap, `STEP_NS_7 / 10);
    for (n = 0; RAMP_STEADY !== 1'b1 && n < 20000; n++) @(negedge REF_CLK);
    cmp_val({RAMP_STEADY, TARGET}, 13'h10c8);
    cmp_val(13'(PG_OE), 13'h0001);
    wr(`ADDR_THRESH, 8'h3f);
    rd(`ADDR_THRESH, 8'h08);
    // Power-good window, external pull and recovery
    VOUT_MEAS = 12'h0c8;
    for (n = 0; PG_OE !== 1'b0 && n < 1200; n++) @(negedge REF_CLK);
    cmp_val(13'(PG_OE), 13'h0000);
    rd(`ADDR_STATUS, 8'h01);
    ext_low = 1'b1;
    repeat (2) @(negedge REF_CLK);
    rd(`ADDR_STATUS, 8'h00);
    ext_low = 1'b0;
    VOUT_MEAS = 12'h0e0;
    repeat (3) @(negedge REF_CLK);
    cmp_val(13'(PG_OE), 13'h0001);
    rd(`ADDR_STATUS, 8'h00);
    VOUT_MEAS = 12'h0c8;
    for (n = 0; PG_OE !== 1'b0 && n < 1200; n++) @(negedge REF_CLK);
    cmp_val(13'(PG_OE), 13'h0000);
    TEMP = 8'h7d;
    repeat (5) @(negedge REF_CLK);
    cmp_val(13'(PWM_EN), 13'h0001);
    TEMP = 8'h19;
    // Turn-off with power good dropped at the command
    wr(`ADDR_RUN, 8'h02);
    repeat (2) @(negedge REF_CLK);
    cmp_val(13'(PG_OE), 13'h0001);
    step_gap(gap);
    cmp_num(gap, `STEP_NS_7 / 10);
    for (n = 0; PWM_EN !== 1'b0 && n < 20000; n++) @(negedge REF_CLK);
    cmp_val({PWM_EN, TARGET}, 13'h0000);
    // Second cycle: no controlled fall, power good held to ramp-down point
    wr(`ADDR_THRESH, 8'h30);
    wr(`ADDR_RAMP, 8'h77);
    wr(`ADDR_RUN, 8'h01);
    for (n = 0; PG_OE !== 1'b0 && n < 20000; n++) @(negedge REF_CLK);
    cmp_val(13'(PG_OE), 13'h0000);
    VOUT_MEAS = 12'h0d8;
    repeat (3) @(negedge REF_CLK);
    cmp_val(13'(PG_OE), 13'h0000);
    VOUT_MEAS = 12'h0bc;
    repeat (3) @(negedge REF_CLK);
    cmp_val(13'(PG_OE), 13'h0001);
    VOUT_MEAS = 12'h0c8;
    // Margin up two steps; window follows the new set-point
    SETPOINT = 12'h0d0;
    repeat (450) @(negedge REF_CLK);
    cmp_val({RAMP_STEADY, TARGET}, 13'h10d0);
    cmp_val(13'(PG_OE), 13'h0000);
    wr(`ADDR_RUN, 8'h00);
    repeat (2) @(negedge REF_CLK);
    cmp_val(13'(PG_OE), 13'h0000);
    repeat (2) @(negedge REF_CLK);
    cmp_val(13'(PG_OE), 13'h0001);
    cmp_val({PWM_EN, TARGET}, 13'h0000);
    // Bus-terminator strap picks the slower fall default
    RST = 1'b1;
    BUS_TERM = 1'b1;
    repeat (4) @(negedge REF_CLK);
    RST = 1'b0;
    repeat (2) @(negedge REF_CLK);
    rd(`ADDR_RAMP, 8'h5b);
    close_out();
  end
endmodule
